// ---- design/icsm_input_clock_select_fault_monitor.sv ----
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
// Overview of operation
// - Automatic selection only ever picks an input currently qualified valid.
// - No valid input at all puts the loop into holdover.
// - Revertive: always highest-priority valid input; switch when better one appears.
// - Non-revertive: keep active input while valid, else best valid one.
// - Hitless on: loop absorbs switch phase step; off: passes at loop rate.
// - Hitless switch only between frequency-locked inputs, down to 8 kHz.
// - Switch across up to 500 ppm, pulling in with normal or fast-lock bandwidth.
// - Lock-lost stays asserted during pull-in; no runt pulses on outputs.
// - Gapped input yields ungapped output at its average frequency.
// - Valid gapped input must not trip loss, range or lock monitors.
// - Per-input loss monitor checks every period, own sensitivity, own disable.
// - Signal-loss has live status and sticky copy held until cleared.
// - Reference pins have loss monitor; outputs disabled unless keep option set.
// - Zero-ppm reference selectable: reference pins or either clock input.
// - Range status combines precise and fast monitors, each disableable; live and sticky.
// - Precise monitor resolves 1 ppm; window 0 to 510 ppm in 2 ppm steps.
// - Precise monitor uses configurable hysteresis between assert and release.
// - Fast monitor in parallel flags shifts beyond 4000 ppm.
// - Lock monitor compares phase detector frequencies; set and clear thresholds.
// - Optional timer delays release of lock-lost to stop chatter.
// - Lock-lost pin follows monitor; live and sticky lock-lost status too.
// - Interrupt on any masked status event; drops once sticky cause cleared.
module icsm_input_clock_select_fault_monitor
  import icsm_pkg::*;
#(
  parameter int unsigned PREC_GATE = PREC_GATE_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic clock_input_0,
  input wire logic clock_input_1,
  input wire logic reference_pins,
  input wire logic [16:0] pd_freq_err,
  output icsm_pll_ctl_t pll_ctl,
  output logic lock_lost_pin,
  output logic status_irq_pin
);

  // Gate length as a counter-width constant
  localparam logic [21:0] PGATE = 22'(PREC_GATE);

  // Software registers
  icsm_ctrl_t ctrl_r;
  logic [31:0] prio_r;
  logic [31:0] los_cfg_r;
  logic [31:0] oof_cfg_r;
  logic [31:0] lol_set_r;
  logic [31:0] lol_clr_r;
  logic [31:0] lol_tmr_r;
  logic [31:0] mask_r;
  logic [NUM_EV-1:0] sticky_r;

  // Bus answer state
  logic wait_r;
  logic [31:0] rdata_r;
  logic wr_go;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic [31:0] wr_clr;

  // Monitor state
  logic [2:0] pin_raw;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] rise;
  logic [2:0] loss_live;
  logic [1:0] oof_live;
  logic ref_edge;
  logic [21:0] pgate_r;
  logic [11:0] fgate_r;
  logic prec_end;
  logic fast_end;

  // Selection and lock state
  logic [1:0] valid;
  logic any_valid;
  logic best;
  logic sel_nxt;
  logic hold_nxt;
  logic sel_r;
  logic hold_r;
  logic switch_r;
  logic hitless_r;
  logic fastlock_r;
  logic odis_r;
  logic lol_r;
  logic [23:0] lol_cnt_r;
  logic irq_r;
  logic [NUM_EV-1:0] ev_live;

  // Byte-lane merge of write data
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // Write lands at the edge where waitrequest is seen low
  assign wr_go = avs_write & ~wait_r;
  // Lane-merged write value over the addressed register, and the clear mask
  assign wr_val = be_merge(rd_mux, avs_writedata, avs_byteenable);
  assign wr_clr = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);

  // Bus handshake: one wait cycle, then one-cycle answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if ((avs_read | avs_write) & wait_r) begin
      wait_r <= 1'b0;
      rdata_r <= avs_read ? rd_mux : 32'h0000_0000;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // Read decode; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == ADDR_CTRL) begin
      rd_mux = ctrl_r;
    end else if (avs_address == ADDR_PRIO) begin
      rd_mux = prio_r;
    end else if (avs_address == ADDR_LOS_CFG) begin
      rd_mux = los_cfg_r;
    end else if (avs_address == ADDR_OOF_CFG) begin
      rd_mux = oof_cfg_r;
    end else if (avs_address == ADDR_LOL_SET) begin
      rd_mux = lol_set_r;
    end else if (avs_address == ADDR_LOL_CLR) begin
      rd_mux = lol_clr_r;
    end else if (avs_address == ADDR_LOL_TMR) begin
      rd_mux = lol_tmr_r;
    end else if (avs_address == ADDR_STATUS) begin
      rd_mux[NUM_EV-1:0] = ev_live;
      rd_mux[ST_ACT] = sel_r;
      rd_mux[ST_ODIS] = odis_r;
    end else if (avs_address == ADDR_STICKY) begin
      rd_mux[NUM_EV-1:0] = sticky_r;
    end else if (avs_address == ADDR_MASK) begin
      rd_mux[NUM_EV-1:0] = mask_r[NUM_EV-1:0];
    end
  end

  // Configuration writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
      prio_r <= PRIO_RST;
      los_cfg_r <= LOS_CFG_RST;
      oof_cfg_r <= OOF_CFG_RST;
      lol_set_r <= LOL_SET_RST;
      lol_clr_r <= LOL_CLR_RST;
      lol_tmr_r <= LOL_TMR_RST;
      mask_r <= MASK_RST;
    end else if (wr_go) begin
      if (avs_address == ADDR_CTRL) begin
        ctrl_r <= {20'h0_0000, wr_val[11:0]};
      end else if (avs_address == ADDR_PRIO) begin
        prio_r <= {24'h00_0000, wr_val[7:0]};
      end else if (avs_address == ADDR_LOS_CFG) begin
        los_cfg_r <= wr_val;
      end else if (avs_address == ADDR_OOF_CFG) begin
        oof_cfg_r <= {16'h0000, wr_val[15:0]};
      end else if (avs_address == ADDR_LOL_SET) begin
        lol_set_r <= {15'h0000, wr_val[16:0]};
      end else if (avs_address == ADDR_LOL_CLR) begin
        lol_clr_r <= {15'h0000, wr_val[16:0]};
      end else if (avs_address == ADDR_LOL_TMR) begin
        lol_tmr_r <= {8'h00, wr_val[23:0]};
      end else if (avs_address == ADDR_MASK) begin
        mask_r <= {25'h000_0000, wr_clr[6:0]};
      end
    end
  end

  // Pin synchronisers; third stage only for edge detect
  assign pin_raw = {reference_pins, clock_input_1, clock_input_0};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign rise = sync2_r & ~sync3_r;

  // Period-based loss monitors: inputs 0,1 and the reference pins
  for (genvar i = 0; i < 3; i++) begin : g_loss
    logic [15:0] per_cnt_r;
    logic loss_r;
    logic [15:0] thr;
    logic en;
    // Reference pins use a fixed threshold and cannot be disabled
    if (i == 2) begin : g_ref
      assign thr = REF_LOS_CYC;
      assign en = 1'b1;
    end else begin : g_in
      assign thr = los_cfg_r[i*16 +: 16];
      assign en = ctrl_r.los_en[i];
    end
    // A gap of up to thr cycles is tolerated, so gapped clocks pass
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        per_cnt_r <= 16'h0000;
        loss_r <= 1'b0;
      end else begin
        if (rise[i]) begin
          per_cnt_r <= 16'h0000; // Every period restarts the watch
        end else if (per_cnt_r != 16'hFFFF) begin
          per_cnt_r <= per_cnt_r + 16'h0001;
        end
        loss_r <= en & (per_cnt_r >= thr);
      end
    end
    assign loss_live[i] = loss_r;
  end

  // Zero-ppm reference choice
  always_comb begin
    case (ctrl_r.oof_ref)
      OREF_IN0: ref_edge = rise[0];
      OREF_IN1: ref_edge = rise[1];
      default: ref_edge = rise[2];
    endcase
  end

  // Shared gate counters in reference edges
  assign prec_end = ref_edge & (pgate_r == PGATE - 22'h00_0001);
  assign fast_end = ref_edge & (fgate_r == FAST_GATE - 12'h001);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pgate_r <= 22'h00_0000;
      fgate_r <= 12'h000;
    end else begin
      if (prec_end) begin
        pgate_r <= 22'h00_0000;
      end else if (ref_edge) begin
        pgate_r <= pgate_r + 22'h00_0001;
      end
      if (fast_end) begin
        fgate_r <= 12'h000;
      end else if (ref_edge) begin
        fgate_r <= fgate_r + 12'h001;
      end
    end
  end

  // Frequency-range monitors per input
  for (genvar i = 0; i < 2; i++) begin : g_oof
    logic [21:0] pcnt_r;
    logic [11:0] fcnt_r;
    logic prec_r;
    logic fast_r;
    logic [21:0] pdev;
    logic [11:0] fdev;
    logic [21:0] win;
    logic [21:0] hys;
    assign pdev = (pcnt_r > PGATE) ? pcnt_r - PGATE : PGATE - pcnt_r;
    assign fdev = (fcnt_r > FAST_GATE) ? fcnt_r - FAST_GATE : FAST_GATE - fcnt_r;
    assign win = {13'h0000, oof_cfg_r[7:0], 1'b0}; // 2 ppm steps
    assign hys = {13'h0000, oof_cfg_r[15:8], 1'b0};
    // One count per gate is 1 ppm at the default gate length
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pcnt_r <= 22'h00_0000;
        fcnt_r <= 12'h000;
        prec_r <= 1'b0;
        fast_r <= 1'b0;
      end else begin
        if (prec_end) begin
          pcnt_r <= {21'h00_0000, rise[i]};
          if (pdev > win) begin
            prec_r <= 1'b1;
          end else if (pdev + hys <= win) begin
            prec_r <= 1'b0;
          end
        end else if (rise[i]) begin
          pcnt_r <= pcnt_r + 22'h00_0001;
        end
        if (fast_end) begin
          fcnt_r <= {11'h000, rise[i]};
          fast_r <= fdev > FAST_LIMIT; // Beyond 4000 ppm
        end else if (rise[i]) begin
          fcnt_r <= fcnt_r + 12'h001;
        end
      end
    end
    assign oof_live[i] = (ctrl_r.prec_en & prec_r) | (ctrl_r.fast_en & fast_r);
  end

  // Input qualification and priority pick
  assign valid = ~loss_live[1:0] & ~oof_live;
  assign any_valid = |valid;
  assign best = (&valid) ? (prio_r[7:4] > prio_r[3:0]) : valid[1];

  // Next selection
  always_comb begin
    sel_nxt = sel_r;
    hold_nxt = hold_r;
    if (!ctrl_r.auto_sel) begin
      sel_nxt = ctrl_r.manual_sel;
      hold_nxt = ~valid[ctrl_r.manual_sel];
    end else if (!any_valid) begin
      hold_nxt = 1'b1;
    end else if (ctrl_r.revertive) begin
      sel_nxt = best;
      hold_nxt = 1'b0;
    end else if (hold_r | ~valid[sel_r]) begin
      sel_nxt = best;
      hold_nxt = 1'b0;
    end
  end

  // Selection state; the loop averages any gaps of the chosen input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_r <= 1'b0;
      hold_r <= 1'b1;
      switch_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      hold_r <= hold_nxt;
      switch_r <= (sel_nxt != sel_r) | (hold_r & ~hold_nxt);
    end
  end

  // Loop controls: hitless only if both inputs lock in frequency
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hitless_r <= 1'b0;
      fastlock_r <= 1'b0;
      odis_r <= 1'b0;
    end else begin
      hitless_r <= ctrl_r.hitless_en & ~oof_live[0] & ~oof_live[1];
      fastlock_r <= ctrl_r.fastlock_en & lol_r; // Pull-in bandwidth choice
      odis_r <= loss_live[2] & ~ctrl_r.keep_out; // Pull-in never disables outputs
    end
  end

  // Lock monitor with set/clear hysteresis and release timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lol_r <= 1'b1;
      lol_cnt_r <= 24'h00_0000;
    end else if (switch_r | hold_r) begin
      lol_r <= 1'b1; // Held through pull
      lol_cnt_r <= 24'h00_0000;
    end else if (pd_freq_err > lol_set_r[16:0]) begin
      lol_r <= 1'b1;
      lol_cnt_r <= 24'h00_0000;
    end else if (lol_r & (pd_freq_err <= lol_clr_r[16:0])) begin
      if (lol_cnt_r >= lol_tmr_r[23:0]) begin
        lol_r <= 1'b0;
      end else begin
        lol_cnt_r <= lol_cnt_r + 24'h00_0001;
      end
    end else begin
      lol_cnt_r <= 24'h00_0000;
    end
  end

  // Live status vector
  assign ev_live = {hold_r, lol_r, oof_live, loss_live[2], loss_live[1:0]};

  // Sticky flags: setting wins over a write-one clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sticky_r <= 7'h00;
    end else if (wr_go & (avs_address == ADDR_STICKY)) begin
      sticky_r <= (sticky_r & ~wr_clr[NUM_EV-1:0]) | ev_live;
    end else begin
      sticky_r <= sticky_r | ev_live;
    end
  end

  // Masked interrupt from the sticky flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(sticky_r & mask_r[NUM_EV-1:0]);
    end
  end

  // Outputs, all registered
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign lock_lost_pin = lol_r;
  assign status_irq_pin = irq_r;
  assign pll_ctl = '{active_input: sel_r, holdover: hold_r, switch_start: switch_r,
                     hitless: hitless_r, fastlock: fastlock_r, output_disable: odis_r};

endmodule : icsm_input_clock_select_fault_monitor

// ---- pkg/icsm_pkg.sv ----
package icsm_pkg;

  // Register byte offsets
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_PRIO = 6'h04;
  localparam logic [5:0] ADDR_LOS_CFG = 6'h08;
  localparam logic [5:0] ADDR_OOF_CFG = 6'h0C;
  localparam logic [5:0] ADDR_LOL_SET = 6'h10;
  localparam logic [5:0] ADDR_LOL_CLR = 6'h14;
  localparam logic [5:0] ADDR_LOL_TMR = 6'h18;
  localparam logic [5:0] ADDR_STATUS = 6'h1C;
  localparam logic [5:0] ADDR_STICKY = 6'h20;
  localparam logic [5:0] ADDR_MASK = 6'h24;

  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0F03;
  localparam logic [31:0] PRIO_RST = 32'h0000_0001;
  localparam logic [31:0] LOS_CFG_RST = 32'h0040_0040;
  localparam logic [31:0] OOF_CFG_RST = 32'h0000_0105;
  localparam logic [31:0] LOL_SET_RST = 32'h0000_000A;
  localparam logic [31:0] LOL_CLR_RST = 32'h0000_0001;
  localparam logic [31:0] LOL_TMR_RST = 32'h0000_0100;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // Status bit positions (live, sticky and mask share bits 0-6; ACT and ODIS are live only)
  localparam int ST_SL0 = 0;
  localparam int ST_SL1 = 1;
  localparam int ST_REF = 2;
  localparam int ST_OOF0 = 3;
  localparam int ST_OOF1 = 4;
  localparam int ST_LOL = 5;
  localparam int ST_HOLD = 6;
  localparam int ST_ACT = 7;
  localparam int ST_ODIS = 8;
  localparam int NUM_EV = 7;

  // Monitor constants
  localparam logic [15:0] REF_LOS_CYC = 16'h0040;
  localparam int unsigned PREC_GATE_DEF = 1000000;
  localparam logic [11:0] FAST_GATE = 12'h01F4;
  localparam logic [11:0] FAST_LIMIT = 12'h0002;

  // Zero-ppm reference choices
  localparam logic [1:0] OREF_PINS = 2'h0;
  localparam logic [1:0] OREF_IN0 = 2'h1;
  localparam logic [1:0] OREF_IN1 = 2'h2;

  // Control register layout
  typedef struct packed {
    logic [19:0] rsvd;
    logic fast_en;
    logic prec_en;
    logic [1:0] los_en;
    logic [1:0] oof_ref;
    logic keep_out;
    logic fastlock_en;
    logic manual_sel;
    logic hitless_en;
    logic revertive;
    logic auto_sel;
  } icsm_ctrl_t;

  // Controls handed to the loop core
  typedef struct packed {
    logic active_input;
    logic holdover;
    logic switch_start;
    logic hitless;
    logic fastlock;
    logic output_disable;
  } icsm_pll_ctl_t;

endpackage : icsm_pkg

// ---- tb/icsm_chk_monitor.sv ----
`timescale 1ns/100ps
// Bus handshake, selector and lock indication checks
module icsm_chk_monitor
  import icsm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [16:0] pd_freq_err,
  input wire icsm_pll_ctl_t pll_ctl,
  input wire logic lock_lost_pin
);
  logic [15:0] clr_cnt_r;
  // Consecutive cycles inside the clear threshold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_cnt_r <= 16'h0000;
    end else if (pd_freq_err > LOL_CLR_RST[16:0]) begin
      clr_cnt_r <= 16'h0000;
    end else if (clr_cnt_r != 16'hFFFF) begin
      clr_cnt_r <= clr_cnt_r + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_idle;
    !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  property p_switch_pulse;
    pll_ctl.switch_start |=> !pll_ctl.switch_start;
  endproperty
  a_switch_pulse: assert property (p_switch_pulse) else $error("switch pulse long");
  property p_switch_lol;
    pll_ctl.switch_start |-> ##[1:2] lock_lost_pin;
  endproperty
  a_switch_lol: assert property (p_switch_lol) else $error("no lock loss on switch");
  property p_hold_lol;
    pll_ctl.holdover && $past(pll_ctl.holdover) |-> lock_lost_pin;
  endproperty
  a_hold_lol: assert property (p_hold_lol) else $error("locked in holdover");
  property p_lol_set;
    (pd_freq_err > LOL_SET_RST[16:0]) [*3] |-> ##[0:8] lock_lost_pin;
  endproperty
  a_lol_set: assert property (p_lol_set) else $error("lock loss not raised");
  property p_lol_clr;
    $fell(lock_lost_pin) |-> clr_cnt_r >= 16'h00FF;
  endproperty
  a_lol_clr: assert property (p_lol_clr) else $error("lock loss cleared early");
endmodule : icsm_chk_monitor

bind icsm_input_clock_select_fault_monitor icsm_chk_monitor i_chk (
  .clk(clk),
  .arst_n(arst_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .pd_freq_err(pd_freq_err),
  .pll_ctl(pll_ctl),
  .lock_lost_pin(lock_lost_pin)
);

// ---- tb/icsm_clk_src.sv ----
`timescale 1ns/100ps
// Upstream sources; a disabled source stops low like a dead clock
module icsm_clk_src #(
  parameter real HALF_NS = 100.0
) (
  input wire logic en0,
  input wire logic en1,
  input wire logic en_ref,
  output logic clock_input_0,
  output logic clock_input_1,
  output logic reference_pins
);
  // Same rate, unrelated start phases; never gapped, so gap limits hold
  initial begin
    clock_input_0 = 1'b0;
    #37;
    forever #(HALF_NS) clock_input_0 = en0 ? ~clock_input_0 : 1'b0;
  end
  initial begin
    clock_input_1 = 1'b0;
    #91;
    forever #(HALF_NS) clock_input_1 = en1 ? ~clock_input_1 : 1'b0;
  end
  initial begin
    reference_pins = 1'b0;
    #13;
    forever #(HALF_NS) reference_pins = en_ref ? ~reference_pins : 1'b0;
  end
endmodule : icsm_clk_src

// ---- tb/icsm_input_clock_select_fault_monitor_test.sv ----
`timescale 1ns/100ps
// Bus driver, source control and selection model
module icsm_input_clock_select_fault_monitor_test
  import icsm_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic en0 = 1'b1;
  logic en1 = 1'b1;
  logic en_ref = 1'b1;
  logic c0, c1, cref, lock_lost_pin, status_irq_pin;
  logic [16:0] pd_freq_err = 17'h0_0064;
  icsm_pll_ctl_t pll_ctl;
  logic [31:0] d;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'h86a0;
  logic [5:0] reg_a[$] = '{ADDR_CTRL, ADDR_PRIO, ADDR_LOS_CFG, ADDR_OOF_CFG, ADDR_LOL_SET,
    ADDR_LOL_CLR, ADDR_LOL_TMR, ADDR_MASK, 6'h3C};
  logic [31:0] reg_e[$] = '{CTRL_RST, PRIO_RST, LOS_CFG_RST, OOF_CFG_RST, LOL_SET_RST,
    LOL_CLR_RST, LOL_TMR_RST, MASK_RST, 32'h0000_0000};

  always #12.5 clk = ~clk;

  icsm_clk_src i_src (.en0(en0), .en1(en1), .en_ref(en_ref), .clock_input_0(c0),
    .clock_input_1(c1), .reference_pins(cref));

  icsm_input_clock_select_fault_monitor #(.PREC_GATE(100)) i_dut (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .clock_input_0(c0), .clock_input_1(c1),
    .reference_pins(cref), .pd_freq_err(pd_freq_err), .pll_ctl(pll_ctl),
    .lock_lost_pin(lock_lost_pin), .status_irq_pin(status_irq_pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) n_errors++;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000, x);
  endtask : rd

  // Poll one status bit until it reaches the expected level
  task automatic wait_st(input int b, input logic v, input int lim);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, s);
      n++;
    end while (s[b] !== v && n < lim);
    chk({31'h0, s[b]}, {31'h0, v});
  endtask : wait_st

  // Selector model: -1 holdover, else chosen input
  function automatic int model_sel(int v0, int v1, int p0, int p1, int rev, int cur);
    if (v0 == 0 && v1 == 0) return -1;
    if (rev == 0 && ((cur == 0 && v0 != 0) || (cur == 1 && v1 != 0))) return cur;
    return (v0 != 0 && (v1 == 0 || p0 >= p1)) ? 0 : 1;
  endfunction : model_sel

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog
  initial begin
    repeat (95000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    foreach (reg_a[i]) begin
      rd(reg_a[i], d);
      chk(d, reg_e[i]);
    end
    $display("test reset values done");
    wait_st(ST_HOLD, 1'b0, 3000);
    wait_st(ST_ACT, 1'(model_sel(1, 1, 1, 0, 1, 0)), 10);
    pd_freq_err <= 17'h0_0000;
    wait_st(ST_LOL, 1'b0, 500);
    chk({31'h0, lock_lost_pin}, 32'h0);
    $display("test first lock done");
    wr(ADDR_MASK, 32'h0000_007F);
    wr(ADDR_STICKY, 32'h0000_007F);
    repeat (3) @(posedge clk);
    chk({31'h0, status_irq_pin}, 32'h0);
    en0 <= 1'b0;
    wait_st(ST_SL0, 1'b1, 100);
    wait_st(ST_ACT, 1'(model_sel(0, 1, 1, 0, 1, 0)), 100);
    chk({31'h0, status_irq_pin}, 32'h1);
    en0 <= 1'b1;
    wait_st(ST_ACT, 1'(model_sel(1, 1, 1, 0, 1, 1)), 3000);
    rd(ADDR_STICKY, d);
    chk(d & 32'h1, 32'h1);
    wr(ADDR_STICKY, 32'h0000_0001);
    rd(ADDR_STICKY, d);
    chk(d & 32'h1, 32'h0);
    wr(ADDR_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk({31'h0, status_irq_pin}, 32'h0);
    $display("test revertive done");
    wr(ADDR_CTRL, CTRL_RST & ~32'h0000_0002);
    en0 <= 1'b0;
    wait_st(ST_ACT, 1'(model_sel(0, 1, 1, 0, 0, 0)), 100);
    en0 <= 1'b1;
    wait_st(ST_SL0, 1'b0, 100);
    repeat (6000) @(posedge clk);
    rd(ADDR_STATUS, d);
    chk({31'h0, d[ST_ACT]}, 32'(model_sel(1, 1, 1, 0, 0, 1)));
    $display("test non-revertive done");
    en0 <= 1'b0;
    en1 <= 1'b0;
    wait_st(ST_HOLD, 1'b1, 100);
    chk({30'h0, pll_ctl.holdover, lock_lost_pin}, 32'h3);
    wr(ADDR_CTRL, CTRL_RST & ~32'h0000_0100);
    en1 <= 1'b1;
    repeat (300) @(posedge clk);
    rd(ADDR_STATUS, d);
    chk(d & 32'h1, 32'h0);
    en0 <= 1'b1;
    wr(ADDR_CTRL, CTRL_RST);
    $display("test holdover done");
    en_ref <= 1'b0;
    wait_st(ST_REF, 1'b1, 100);
    wait_st(ST_ODIS, 1'b1, 20);
    chk({31'h0, pll_ctl.output_disable}, 32'h1);
    wr(ADDR_CTRL, CTRL_RST | 32'h0000_0024);
    wait_st(ST_ODIS, 1'b0, 20);
    en_ref <= 1'b1;
    wait_st(ST_REF, 1'b0, 100);
    $display("test reference loss done");
    wait_st(ST_HOLD, 1'b0, 3000);
    wait_st(ST_LOL, 1'b0, 3000);
    repeat (3) begin
      pd_freq_err <= 17'(11 + {$random(seed)} % 1000);
      wait_st(ST_LOL, 1'b1, 20);
      chk({31'h0, lock_lost_pin}, 32'h1);
      pd_freq_err <= 17'h0_0000;
      wait_st(ST_LOL, 1'b0, 500);
    end
    wait_st(ST_OOF0, 1'b0, 3000);
    wait_st(ST_OOF1, 1'b0, 3000);
    repeat (2) @(posedge clk);
    chk({31'h0, pll_ctl.hitless}, 32'h1);
    $display("test lock monitor done");
    tally_and_finish;
  end
endmodule : icsm_input_clock_select_fault_monitor_test
